// ===== include/dtec_map.svh
// Purpose: offsets, field positions, reset values and rates of the dual timer/event counter
// Assumes: data-memory byte locations on a 9-bit data address
// Notes:   definitions only
`ifndef DTEC_MAP_SVH
`define DTEC_MAP_SVH

// ==========================================================================
// data-memory locations
`define DTEC_ADDR_W         9
`define DTEC_U0_HIGH        9'h00C
`define DTEC_U0_LOW         9'h00D
`define DTEC_U0_CTRL        9'h00E
`define DTEC_U1_HIGH        9'h00F
`define DTEC_U1_LOW         9'h010
`define DTEC_U1_CTRL        9'h011

// ==========================================================================
// control register fields
`define DTEC_EDGE_BIT       3
`define DTEC_RUN_BIT        4
`define DTEC_MODE_LSB       6
`define DTEC_MODE_MSB       7
`define DTEC_CTRL_WMASK     8'hD8
`define DTEC_CTRL_RESET     8'h08

// ==========================================================================
// counting
`define DTEC_COUNT_MAX      16'hFFFF
`define DTEC_CLK_DIV        4
`define DTEC_DIV_LAST       2'h3

`endif

// ===== include/dtec_pkg.sv
// Purpose: types shared by the dual timer/event counter
// Assumes: nothing beyond the constants header
// Notes:   mode codes follow the control register encoding
package dtec_pkg;

  // ========================================================================
  // operating mode, control bits 7:6
  typedef enum logic [1:0] {
    DTEC_MODE_UNUSED = 2'b00,
    DTEC_MODE_EVENT  = 2'b01,
    DTEC_MODE_TIMER  = 2'b10,
    DTEC_MODE_PULSE  = 2'b11
  } dtec_mode_t;

  // pulse-width measurement state
  typedef enum logic {
    DTEC_PW_WAIT = 1'b0,
    DTEC_PW_MEAS = 1'b1
  } dtec_pw_t;

  // which register of a unit is addressed
  typedef enum logic [1:0] {
    DTEC_SEL_NONE = 2'b00,
    DTEC_SEL_HIGH = 2'b01,
    DTEC_SEL_LOW  = 2'b10,
    DTEC_SEL_CTRL = 2'b11
  } dtec_sel_t;

endpackage

// ===== verilog/dtec_top.sv
// Purpose: two 16-bit count-up timer/event counters on the CPU data-memory bus
// Assumes: one clk_sys domain; count input pins are asynchronous
// Notes:   read data is registered one cycle after the read strobe
//
// Overview of operation
// - two identical 16-bit counters, clock divided four
// - low byte write only fills holding buffer
// - high byte write loads preload with buffer
// - high byte read latches live low byte
// - low byte read returns buffer; read high first
// - control bits 0-2 and 5 read zero
// - bit 3 picks active edge of input
// - bit 4 gates counting
// - bits 7:6 select event, timer, pulse-width mode
// - event mode counts pin edges, timer and pulse-width the instruction clock
// - overflow reloads from preload, sets request flag
// - pulse-width counts from start edge, clears run
// - finished measurement held until run set again
// - measurement starts on edge, not on level
// - pulse-width overflow reloads and raises flag too
// - run cleared by hardware only in pulse-width mode
// - overflow is a wake-up source
// - cleared interrupt enable blocks overflow service
// - stopped unit copies preload into counter
// - running unit takes new preload at overflow
// - high byte read suppresses the counter clock
`timescale 1ns/1ps
`include "dtec_map.svh"

module dtec_top (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst_b,
  // cpu data-memory access
  input  wire logic [`DTEC_ADDR_W-1:0]       mem_addr,
  input  wire logic                          mem_wr,
  input  wire logic                          mem_rd,
  input  wire logic [7:0]                    mem_wdata,
  output logic      [7:0]                    mem_rdata,
  // external count input pins
  input  wire logic                          unit0_external_count_input,
  input  wire logic                          unit1_external_count_input,
  // interrupt control register side
  input  wire logic                          unit0_irq_enable,
  input  wire logic                          unit1_irq_enable,
  input  wire logic                          unit0_flag_clear,
  input  wire logic                          unit1_flag_clear,
  output logic                               unit0_overflow_flag,
  output logic                               unit1_overflow_flag,
  output logic                               unit0_irq_req,
  output logic                               unit1_irq_req,
  // halt release
  output logic                               wakeup_req
);
  import dtec_pkg::*;

  // ========================================================================
  // address decode
  function automatic dtec_sel_t reg_sel(input logic [`DTEC_ADDR_W-1:0] a, input logic u);
    dtec_sel_t s;
    s = DTEC_SEL_NONE;
    if (!u) begin
      if (a == `DTEC_U0_HIGH) s = DTEC_SEL_HIGH;
      if (a == `DTEC_U0_LOW)  s = DTEC_SEL_LOW;
      if (a == `DTEC_U0_CTRL) s = DTEC_SEL_CTRL;
    end else begin
      if (a == `DTEC_U1_HIGH) s = DTEC_SEL_HIGH;
      if (a == `DTEC_U1_LOW)  s = DTEC_SEL_LOW;
      if (a == `DTEC_U1_CTRL) s = DTEC_SEL_CTRL;
    end
    return s;
  endfunction

  dtec_sel_t   sel      [2];
  logic        wr_high  [2];
  logic        wr_low   [2];
  logic        wr_ctrl  [2];
  logic        rd_high  [2];
  logic        rd_low   [2];
  logic        rd_ctrl  [2];

  always_comb begin
    for (int u = 0; u < 2; u++) begin
      sel[u]     = reg_sel(mem_addr, u[0]);
      wr_high[u] = mem_wr && (sel[u] == DTEC_SEL_HIGH);
      wr_low[u]  = mem_wr && (sel[u] == DTEC_SEL_LOW);
      wr_ctrl[u] = mem_wr && (sel[u] == DTEC_SEL_CTRL);
      rd_high[u] = mem_rd && (sel[u] == DTEC_SEL_HIGH);
      rd_low[u]  = mem_rd && (sel[u] == DTEC_SEL_LOW);
      rd_ctrl[u] = mem_rd && (sel[u] == DTEC_SEL_CTRL);
    end
  end

  // ========================================================================
  // instruction clock: one-cycle enable every fourth system clock
  logic [1:0]  div_cnt;
  logic        tick;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end

  assign tick = (div_cnt == `DTEC_DIV_LAST);

  // ========================================================================
  // input pin synchronisers and edge detect
  logic [1:0]  pin_meta;
  logic [1:0]  pin_sync;
  logic [1:0]  pin_prev;
  logic        pin_rise [2];
  logic        pin_fall [2];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
      pin_prev <= 2'h0;
    end else begin
      pin_meta <= {unit1_external_count_input, unit0_external_count_input};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  always_comb begin
    for (int u = 0; u < 2; u++) begin
      pin_rise[u] = pin_sync[u] && !pin_prev[u];
      pin_fall[u] = !pin_sync[u] && pin_prev[u];
    end
  end

  // ========================================================================
  // per-unit state
  logic [15:0] count    [2];
  logic [15:0] preload  [2];
  logic [7:0]  low_buf  [2];
  logic        edge_sel [2];
  logic        run      [2];
  dtec_mode_t  mode     [2];
  dtec_pw_t    pw_state [2];
  logic        flag     [2];

  logic        ev_edge  [2];
  logic        pw_start [2];
  logic        pw_end   [2];
  logic        advance  [2];
  logic        ovf      [2];
  logic        next_flag[2];

  always_comb begin
    for (int u = 0; u < 2; u++) begin
      // event mode: 0 counts rising, 1 counts falling
      ev_edge[u]  = edge_sel[u] ? pin_fall[u] : pin_rise[u];
      // pulse-width: 1 measures the high level, 0 the low level
      pw_start[u] = edge_sel[u] ? pin_rise[u] : pin_fall[u];
      pw_end[u]   = edge_sel[u] ? pin_fall[u] : pin_rise[u];
      advance[u]  = 1'b0;
      if (run[u] && !rd_high[u]) begin
        case (mode[u])
          DTEC_MODE_EVENT: advance[u] = ev_edge[u];
          DTEC_MODE_TIMER: advance[u] = tick;
          DTEC_MODE_PULSE: advance[u] = tick && (pw_state[u] == DTEC_PW_MEAS);
          default:         advance[u] = 1'b0;
        endcase
      end
      ovf[u]       = advance[u] && (count[u] == `DTEC_COUNT_MAX);
      // a set in the clearing cycle wins
      next_flag[u] = ovf[u] || (flag[u] && !(u == 0 ? unit0_flag_clear : unit1_flag_clear));
    end
  end

  // preload and holding buffer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int u = 0; u < 2; u++) begin
        preload[u] <= 16'h0000;
        low_buf[u] <= 8'h00;
      end
    end else begin
      for (int u = 0; u < 2; u++) begin
        if (wr_low[u]) begin
          low_buf[u] <= mem_wdata;
        end else if (rd_high[u]) begin
          low_buf[u] <= count[u][7:0];
        end
        if (wr_high[u]) begin
          preload[u] <= {mem_wdata, low_buf[u]};
        end
      end
    end
  end

  // counter
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int u = 0; u < 2; u++) begin
        count[u] <= 16'h0000;
      end
    end else begin
      for (int u = 0; u < 2; u++) begin
        if (wr_high[u] && !run[u]) begin
          count[u] <= {mem_wdata, low_buf[u]};
        end else if (ovf[u]) begin
          // old preload when a write lands in the same cycle
          count[u] <= preload[u];
        end else if (advance[u]) begin
          count[u] <= count[u] + 16'h0001;
        end
      end
    end
  end

  // control register; a software write wins over the self-clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int u = 0; u < 2; u++) begin
        edge_sel[u] <= 1'(`DTEC_CTRL_RESET >> `DTEC_EDGE_BIT);
        run[u]      <= 1'b0;
        mode[u]     <= DTEC_MODE_UNUSED;
      end
    end else begin
      for (int u = 0; u < 2; u++) begin
        if (wr_ctrl[u]) begin
          edge_sel[u] <= mem_wdata[`DTEC_EDGE_BIT];
          run[u]      <= mem_wdata[`DTEC_RUN_BIT];
          mode[u]     <= dtec_mode_t'(mem_wdata[`DTEC_MODE_MSB:`DTEC_MODE_LSB]);
        end else if (mode[u] == DTEC_MODE_PULSE && pw_state[u] == DTEC_PW_MEAS
                     && pw_end[u]) begin
          run[u] <= 1'b0;
        end
      end
    end
  end

  // pulse-width measurement sequencing
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int u = 0; u < 2; u++) begin
        pw_state[u] <= DTEC_PW_WAIT;
      end
    end else begin
      for (int u = 0; u < 2; u++) begin
        if (!run[u] || mode[u] != DTEC_MODE_PULSE || wr_ctrl[u]) begin
          // held until run is set again, one shot per arm
          pw_state[u] <= DTEC_PW_WAIT;
        end else begin
          case (pw_state[u])
            DTEC_PW_WAIT: if (pw_start[u]) pw_state[u] <= DTEC_PW_MEAS;
            DTEC_PW_MEAS: if (pw_end[u])   pw_state[u] <= DTEC_PW_WAIT;
            default:      pw_state[u] <= DTEC_PW_WAIT;
          endcase
        end
      end
    end
  end

  // ========================================================================
  // flags, interrupt requests and wake-up
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int u = 0; u < 2; u++) begin
        flag[u] <= 1'b0;
      end
      unit0_overflow_flag <= 1'b0;
      unit1_overflow_flag <= 1'b0;
      unit0_irq_req       <= 1'b0;
      unit1_irq_req       <= 1'b0;
      wakeup_req          <= 1'b0;
    end else begin
      for (int u = 0; u < 2; u++) begin
        flag[u] <= next_flag[u];
      end
      unit0_overflow_flag <= next_flag[0];
      unit1_overflow_flag <= next_flag[1];
      unit0_irq_req       <= next_flag[0] && unit0_irq_enable;
      unit1_irq_req       <= next_flag[1] && unit1_irq_enable;
      // wake regardless of interrupt enable
      wakeup_req          <= ovf[0] || ovf[1];
    end
  end

  // ========================================================================
  // read data
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    for (int u = 0; u < 2; u++) begin
      if (rd_high[u]) next_rdata = count[u][15:8];
      if (rd_low[u])  next_rdata = low_buf[u];
      if (rd_ctrl[u]) next_rdata = {mode[u], 1'b0, run[u], edge_sel[u], 3'h0};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mem_rdata <= 8'h00;
    end else if (mem_rd) begin
      mem_rdata <= next_rdata;
    end
  end

  // ========================================================================
  // checks on unit 0
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_low_write_keeps_preload;
    wr_low[0] && !wr_high[0] |=> $stable(preload[0]) && low_buf[0] == $past(mem_wdata);
  endproperty
  a_low_write_keeps_preload: assert property (p_low_write_keeps_preload)
    else $error("low byte write changed preload");

  property p_high_write_loads;
    wr_high[0] |=> preload[0] == {$past(mem_wdata), $past(low_buf[0])};
  endproperty
  a_high_write_loads: assert property (p_high_write_loads)
    else $error("high byte write did not load preload");

  property p_high_read;
    rd_high[0] && !mem_wr |=> mem_rdata == $past(count[0][15:8])
                              && low_buf[0] == $past(count[0][7:0]);
  endproperty
  a_high_read: assert property (p_high_read)
    else $error("high byte read returned wrong data");

  property p_low_read;
    rd_low[0] |=> mem_rdata == $past(low_buf[0]);
  endproperty
  a_low_read: assert property (p_low_read)
    else $error("low byte read not from buffer");

  property p_ctrl_zero_bits;
    rd_ctrl[0] |=> mem_rdata[2:0] == 3'h0 && !mem_rdata[5];
  endproperty
  a_ctrl_zero_bits: assert property (p_ctrl_zero_bits)
    else $error("unimplemented control bits read nonzero");

  property p_stopped_holds;
    !run[0] && !wr_high[0] |=> $stable(count[0]);
  endproperty
  a_stopped_holds: assert property (p_stopped_holds)
    else $error("counter moved while stopped");

  property p_overflow_reload;
    ovf[0] |=> count[0] == $past(preload[0]) && flag[0] && wakeup_req;
  endproperty
  a_overflow_reload: assert property (p_overflow_reload)
    else $error("overflow did not reload and flag");

  property p_pw_end_clears_run;
    mode[0] == DTEC_MODE_PULSE && pw_state[0] == DTEC_PW_MEAS && pw_end[0] && !wr_ctrl[0]
      |=> !run[0] ##1 !run[0] || $past(wr_ctrl[0]);
  endproperty
  a_pw_end_clears_run: assert property (p_pw_end_clears_run)
    else $error("measurement end did not clear run");

  property p_run_cleared_by_sw;
    $fell(run[0]) && $past(mode[0]) != DTEC_MODE_PULSE |-> $past(wr_ctrl[0]);
  endproperty
  a_run_cleared_by_sw: assert property (p_run_cleared_by_sw)
    else $error("run cleared outside pulse-width mode");

  property p_irq_gated;
    !unit0_irq_enable |=> !unit0_irq_req;
  endproperty
  a_irq_gated: assert property (p_irq_gated)
    else $error("interrupt raised while disabled");

  property p_stopped_copy;
    wr_high[0] && !run[0] |=> count[0] == preload[0];
  endproperty
  a_stopped_copy: assert property (p_stopped_copy)
    else $error("stopped preload write not copied");

  property p_read_blocks_clock;
    rd_high[0] && !wr_high[0] |=> count[0] == $past(count[0]);
  endproperty
  a_read_blocks_clock: assert property (p_read_blocks_clock)
    else $error("counter advanced during high read");

  property p_timer_rate;
    mode[0] == DTEC_MODE_TIMER && advance[0] |=> !advance[0] [*3];
  endproperty
  a_timer_rate: assert property (p_timer_rate)
    else $error("timer advanced faster than one in four");

  c_overflow:  cover property (ovf[0]);
  c_pw_done:   cover property (pw_state[0] == DTEC_PW_MEAS ##1 pw_state[0] == DTEC_PW_WAIT
                               && !run[0]);
  c_high_read: cover property (rd_high[0] && run[0]);

endmodule // dtec_top

// ===== dv/dtec_cpu_model.sv
// Purpose: cpu core and count pin model facing the dual timer/event counter
// Assumes: one-cycle read/write strobes, read data registered one cycle after the read edge
// Notes:   released bus lines show the inverse of their last value, never a stale copy
`timescale 1ns/1ps

module dtec_cpu_model (
  // clock
  input  wire logic       clk_sys,
  // data-memory access
  output logic [8:0]      mem_addr,
  output logic            mem_wr,
  output logic            mem_rd,
  output logic [7:0]      mem_wdata,
  input  wire logic [7:0] mem_rdata,
  // external count pins
  output logic [1:0]      pin
);
  initial begin
    mem_addr  = 9'h1FF;
    mem_wr    = 1'b0;
    mem_rd    = 1'b0;
    mem_wdata = 8'h00;
    pin       = 2'h0;
  end

  // ========================================================================
  // bus cycles
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    mem_addr  <= a;
    mem_wdata <= d;
    mem_wr    <= 1'b1;
    @(posedge clk_sys);
    mem_wr    <= 1'b0;
    mem_addr  <= ~a;
    mem_wdata <= ~d;
  endtask

  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    mem_addr <= a;
    mem_rd   <= 1'b1;
    @(posedge clk_sys);
    mem_rd   <= 1'b0;
    mem_addr <= ~a;
    // registered answer stands from the edge after the read edge
    @(posedge clk_sys);
    d = mem_rdata;
  endtask

  // high first so the low byte comes from the same instant; a tick may be lost
  task automatic rd16(input logic [8:0] base, output logic [15:0] v);
    logic [7:0] hi;
    logic [7:0] lo;
    rd(base, hi);
    rd(base + 9'h001, lo);
    v = {hi, lo};
  endtask

  // pin change, then time for the two-flop synchroniser and the count
  task automatic set_pin(input int u, input logic v);
    @(posedge clk_sys);
    pin[u] <= v;
    repeat (6) @(posedge clk_sys);
  endtask

endmodule // dtec_cpu_model

// ===== dv/testbench.sv
// Purpose: self-checking bench for the dual timer/event counter
// Assumes: cpu model drives bus and pins, bench drives interrupt side
// Notes:   every scenario runs on both units
`timescale 1ns/1ps
`include "dtec_map.svh"

module testbench;
  import dtec_pkg::*;

  logic        clk_sys = 1'b0;
  logic        rst_b   = 1'b0;
  logic [8:0]  mem_addr;
  logic        mem_wr;
  logic        mem_rd;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata;
  logic [1:0]  pin;
  logic [1:0]  irq_en  = 2'h0;
  logic [1:0]  fclr    = 2'h0;
  logic [1:0]  flag;
  logic [1:0]  irq;
  logic        wake;
  int          err_count = 0;
  int          tests_run = 0;
  int          wake_cnt  = 0;

  // software mode choice of the shipped part; scenarios use the others too
  localparam logic [7:0] CTRL_TIMER_RUN = 8'h90;

  always #5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) if (wake === 1'b1) wake_cnt++;

  dtec_cpu_model u_cpu (.clk_sys(clk_sys), .mem_addr(mem_addr), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .pin(pin));

  dtec_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .mem_addr(mem_addr), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .unit0_external_count_input(pin[0]), .unit1_external_count_input(pin[1]),
    .unit0_irq_enable(irq_en[0]), .unit1_irq_enable(irq_en[1]),
    .unit0_flag_clear(fclr[0]), .unit1_flag_clear(fclr[1]),
    .unit0_overflow_flag(flag[0]), .unit1_overflow_flag(flag[1]),
    .unit0_irq_req(irq[0]), .unit1_irq_req(irq[1]), .wakeup_req(wake));

  // ========================================================================
  // checking and closing
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic test_done;
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  function automatic logic [8:0] base(input int u);
    return (u == 1) ? `DTEC_U1_HIGH : `DTEC_U0_HIGH;
  endfunction

  // stopped unit: preload write lands in the counter too
  task automatic load(input int u, input logic [15:0] v);
    u_cpu.wr(base(u) + 9'h001, v[7:0]);
    u_cpu.wr(base(u), v[15:8]);
  endtask

  // ========================================================================
  // scenarios
  task automatic t_regs(input int u);
    logic [7:0]  b;
    logic [15:0] v;
    u_cpu.rd(base(u) + 9'h002, b);
    chk(b, 8'h08, "control after reset");
    u_cpu.rd(9'h00B, b);
    chk(b, 8'h00, "unmapped read");
    u_cpu.wr(base(u) + 9'h002, 8'h27);
    u_cpu.rd(base(u) + 9'h002, b);
    chk(b, 8'h00, "unused control bits");
    u_cpu.wr(base(u) + 9'h001, 8'hFE);
    u_cpu.rd16(base(u), v);
    chk(v, 16'h0000, "low write alone");
    load(u, 16'hFFFE);
    u_cpu.rd16(base(u), v);
    chk(v, 16'hFFFE, "preload into stopped count");
  endtask

  task automatic t_event(input int u);
    logic [15:0] v;
    logic [7:0]  b;
    int          w;
    irq_en[u] <= 1'b1;
    u_cpu.wr(base(u) + 9'h002, 8'h50);
    u_cpu.set_pin(u, 1'b1);
    u_cpu.rd16(base(u), v);
    chk(v, 16'hFFFF, "rising edge counted");
    load(u, 16'h0010);
    u_cpu.rd16(base(u), v);
    chk(v, 16'hFFFF, "running preload write");
    w = wake_cnt;
    u_cpu.set_pin(u, 1'b0);
    chk(flag[u], 1'b0, "falling edge ignored");
    u_cpu.set_pin(u, 1'b1);
    chk({flag[u], irq[u]}, 2'h3, "overflow flag and request");
    chk(wake_cnt - w, 1, "one wake pulse");
    u_cpu.rd16(base(u), v);
    chk(v, 16'h0010, "reload from preload");
    u_cpu.rd(base(u) + 9'h002, b);
    chk(b, 8'h50, "run kept after overflow");
    irq_en[u] <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({flag[u], irq[u]}, 2'h2, "request masked");
    fclr[u] <= 1'b1;
    @(posedge clk_sys);
    fclr[u] <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(flag[u], 1'b0, "flag cleared");
    u_cpu.wr(base(u) + 9'h002, 8'h58);
    u_cpu.set_pin(u, 1'b0);
    u_cpu.set_pin(u, 1'b1);
    u_cpu.rd16(base(u), v);
    chk(v, 16'h0011, "falling edge selected");
    // stop the unit so the next preload lands in the counter
    u_cpu.wr(base(u) + 9'h002, 8'h08);
  endtask

  task automatic t_timer(input int u);
    logic [15:0] v;
    logic [15:0] h;
    load(u, 16'h0000);
    repeat (40) @(posedge clk_sys);
    u_cpu.rd16(base(u), v);
    chk(v, 16'h0000, "stopped unit holds");
    u_cpu.wr(base(u) + 9'h002, CTRL_TIMER_RUN);
    repeat (40) @(posedge clk_sys);
    u_cpu.wr(base(u) + 9'h002, 8'h80);
    u_cpu.rd16(base(u), v);
    chk(v >= 16'h0009 && v <= 16'h000E, 16'h1, "divide by four rate");
    u_cpu.wr(base(u) + 9'h002, 8'h10);
    repeat (40) @(posedge clk_sys);
    u_cpu.rd16(base(u), h);
    chk(h, v, "unused mode never counts");
  endtask

  task automatic t_pulse(input int u);
    logic [15:0] v;
    logic [15:0] h;
    logic [7:0]  b;
    // previous scenario leaves run set; stop so the load reaches the count
    u_cpu.wr(base(u) + 9'h002, 8'h08);
    load(u, 16'h0000);
    u_cpu.set_pin(u, 1'b1);
    u_cpu.wr(base(u) + 9'h002, 8'hD8);
    repeat (20) @(posedge clk_sys);
    u_cpu.set_pin(u, 1'b0);
    u_cpu.rd16(base(u), v);
    chk(v, 16'h0000, "level does not start");
    u_cpu.set_pin(u, 1'b1);
    repeat (40) @(posedge clk_sys);
    u_cpu.set_pin(u, 1'b0);
    u_cpu.rd(base(u) + 9'h002, b);
    chk(b, 8'hC8, "run cleared at end");
    u_cpu.rd16(base(u), v);
    chk(v >= 16'h000A && v <= 16'h0010, 16'h1, "high time measured");
    u_cpu.set_pin(u, 1'b1);
    repeat (20) @(posedge clk_sys);
    u_cpu.set_pin(u, 1'b0);
    u_cpu.rd16(base(u), h);
    chk(h, v, "single measurement held");
    load(u, 16'hFFFE);
    u_cpu.wr(base(u) + 9'h002, 8'hD8);
    u_cpu.set_pin(u, 1'b1);
    repeat (20) @(posedge clk_sys);
    u_cpu.set_pin(u, 1'b0);
    chk(flag[u], 1'b1, "rearmed and overflowed");
    fclr[u] <= 1'b1;
    @(posedge clk_sys);
    fclr[u] <= 1'b0;
  endtask

  // ========================================================================
  // main sequence and watchdog
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int u = 0; u < 2; u++) begin
      t_regs(u);
      t_event(u);
      t_timer(u);
      t_pulse(u);
    end
    test_done();
  end

  // whole run needs fewer than a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    test_done();
  end

endmodule // testbench
